/* File: rtl/soft_reset_pkg.sv */
package soft_reset_pkg;
  localparam logic [7:0] SOFT_RESET_OFFSET = 8'h40;
  localparam logic [7:0] INT_STATUS2_OFFSET = 8'h3e;
  localparam logic [7:0] INT_ENABLE2_OFFSET = 8'h3f;
  localparam logic [7:0] SOFT_RESET_RESET = 8'h00;
  localparam logic [7:0] INT_STATUS2_RESET = 8'h00;
  localparam logic [7:0] INT_ENABLE2_RESET = 8'h00;
  localparam int BIT_SW_RESET = 0;
  localparam int BIT_GCP_ENABLE = 2;
  localparam int BIT_CLK_STABLE = 6;
  localparam int BIT_ALT_STABLE = 7;
  localparam int BIT_LINK_STABLE_INT = 0;
  localparam logic [7:0] SOFT_RESET_WMASK = 8'h05;
  localparam logic [7:0] INT_ENABLE2_WMASK = 8'h03;
  localparam logic [7:0] INT_STATUS2_WMASK = 8'h03;
  localparam int STABLE_CYCLES = 16;
endpackage : soft_reset_pkg

/* File: rtl/stability_filter.sv */
`timescale 1ns/1ps
module stability_filter #(
  parameter int COUNT = 16
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clear,
  input  wire logic lock,
  output logic      stable
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] count;
  wire           done = (count == CW'(COUNT));

  // a zero window would report stability with no lock history at all
  if (COUNT < 1) begin : g_bad_count
    $error("COUNT must be at least one");
  end

  // stability only after lock has held a full window
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count  <= '0;
      stable <= 1'b0;
    end else if (clear || !lock) begin
      count  <= '0;
      stable <= 1'b0;
    end else begin
      if (!done) count <= count + CW'(1);
      stable <= done;
    end
  end
endmodule : stability_filter

/* File: rtl/tmds_tx_soft_reset_control.sv */
// Function
// - while the reset bit is one all internal sections reset, user registers kept.
// - bit two enables deep colour general control packets.
// - bit six reads one only while the derived link clock is stable.
// - any input_pixel_clock change drops bit six until stability returns.
// - a bit-six change sets pending bit 0x3e[0], reported when 0x3f[0] is set.
// - bit seven reports stability by an alternative check.
// - bit seven changes never set a pending flag or interrupt.
// - pending bits show events even with their enable off.
// - writing one clears a pending bit, writing zero leaves it.
`timescale 1ns/1ps
module tmds_tx_soft_reset_control
  import soft_reset_pkg::*;
#(
  parameter int STABLE_COUNT = STABLE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic       pixel_clock_lock,
  input  wire logic       pixel_clock_alt_lock,
  input  wire logic       pixel_clock_change,
  output logic            section_reset,
  output logic            gcp_enable,
  output logic            link_stable_irq
);
  logic       sw_reset;
  logic       gcp_en;
  logic       stable_q;
  logic [7:0] int_status2;
  logic [7:0] int_enable2;
  logic       clk_stable;
  logic       alt_stable;

  // the filters cannot serve an empty stability window
  if (STABLE_COUNT < 1) begin : g_bad_count
    $error("STABLE_COUNT must be at least one");
  end

  wire sel_ctrl = (reg_addr == SOFT_RESET_OFFSET);
  wire sel_stat = (reg_addr == INT_STATUS2_OFFSET);
  wire sel_en   = (reg_addr == INT_ENABLE2_OFFSET);
  wire wr_ctrl  = reg_wr && sel_ctrl;
  wire wr_stat  = reg_wr && sel_stat;
  wire wr_en    = reg_wr && sel_en;

  // bit six and seven come from hardware only; reserved bits stay zero
  wire [7:0] ctrl_view = (8'(alt_stable) << BIT_ALT_STABLE)
                       | (8'(clk_stable) << BIT_CLK_STABLE)
                       | (8'(gcp_en)     << BIT_GCP_ENABLE)
                       | (8'(sw_reset)   << BIT_SW_RESET);
  wire [7:0] next_rdata = sel_ctrl ? ctrl_view :
                          sel_stat ? int_status2 :
                          sel_en   ? int_enable2 : 8'h00;

  // only the main stable bit raises an event; the alternate one never does
  wire stable_edge = (clk_stable != stable_q);
  wire [7:0] event_set = 8'(stable_edge) << BIT_LINK_STABLE_INT;
  wire [7:0] clr_mask = wr_stat ? (reg_wdata & INT_STATUS2_WMASK) : 8'h00;
  // set beats clear so an edge in the clearing cycle is kept
  wire [7:0] next_status = (int_status2 & ~clr_mask) | event_set;
  wire next_irq = |(next_status & int_enable2);

  // index 0 is the main checker, index 1 the alternate one
  wire [1:0] lock_in = {pixel_clock_alt_lock, pixel_clock_lock};
  wire [1:0] stable_vec;
  // pixel clock change restarts the filters, as does soft reset
  wire       filter_clear = pixel_clock_change | sw_reset;

  for (genvar g = 0; g < 2; g++) begin : g_filter
    stability_filter #(.COUNT(STABLE_COUNT)) i_stability_filter (
      .clk    (clk),
      .rst_n  (rst_n),
      .clear  (filter_clear),
      .lock   (lock_in[g]),
      .stable (stable_vec[g])
    );
  end

  assign clk_stable = stable_vec[0];
  assign alt_stable = stable_vec[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_reset <= SOFT_RESET_RESET[BIT_SW_RESET];
      gcp_en   <= SOFT_RESET_RESET[BIT_GCP_ENABLE];
    end else if (wr_ctrl) begin
      sw_reset <= reg_wdata[BIT_SW_RESET];
      gcp_en   <= reg_wdata[BIT_GCP_ENABLE];
    end
  end

  // soft reset leaves these user registers intact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_enable2 <= INT_ENABLE2_RESET;
    end else if (wr_en) begin
      int_enable2 <= reg_wdata & INT_ENABLE2_WMASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_status2 <= INT_STATUS2_RESET;
      stable_q    <= 1'b0;
    end else begin
      int_status2 <= next_status;
      stable_q    <= clk_stable;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata       <= 8'h00;
      section_reset   <= 1'b0;
      gcp_enable      <= 1'b0;
      link_stable_irq <= 1'b0;
    end else begin
      if (reg_rd) reg_rdata <= next_rdata;
      section_reset   <= sw_reset;
      gcp_enable      <= gcp_en && !sw_reset;
      link_stable_irq <= next_irq;
    end
  end

  // named views of the pending, enable and write bits of the stable event
  wire pend_bit = int_status2[BIT_LINK_STABLE_INT];
  wire en_bit   = int_enable2[BIT_LINK_STABLE_INT];
  wire clr_bit  = reg_wdata[BIT_LINK_STABLE_INT];

  a_reset_follow: assert property (
    @(posedge clk) disable iff (!rst_n)
    sw_reset |=> section_reset)
    else $error("section reset not following bit zero");

  a_reset_release: assert property (
    @(posedge clk) disable iff (!rst_n)
    !sw_reset |=> !section_reset)
    else $error("section reset held after bit zero cleared");

  a_reset_filters: assert property (
    @(posedge clk) disable iff (!rst_n)
    sw_reset |=> (!clk_stable && !alt_stable))
    else $error("clock checkers not reset by soft reset");

  a_gcp_gate: assert property (
    @(posedge clk) disable iff (!rst_n)
    gcp_enable |-> $past(gcp_en))
    else $error("packets sent without enable");

  a_gcp_on: assert property (
    @(posedge clk) disable iff (!rst_n)
    (gcp_en && !sw_reset) |=> gcp_enable)
    else $error("packets not sent while enabled");

  a_gcp_held: assert property (
    @(posedge clk) disable iff (!rst_n)
    sw_reset |=> !gcp_enable)
    else $error("packets sent during soft reset");

  a_change_drops: assert property (
    @(posedge clk) disable iff (!rst_n)
    pixel_clock_change |=> !clk_stable)
    else $error("stable bit not dropped on clock change");

  a_unlock_low: assert property (
    @(posedge clk) disable iff (!rst_n)
    !pixel_clock_lock |=> !clk_stable)
    else $error("stable shown without lock");

  a_stable_lock: assert property (
    @(posedge clk) disable iff (!rst_n)
    clk_stable |-> $past(pixel_clock_lock))
    else $error("stable shown after an unlocked cycle");

  a_alt_unlock: assert property (
    @(posedge clk) disable iff (!rst_n)
    !pixel_clock_alt_lock |=> !alt_stable)
    else $error("alternate stable shown without lock");

  a_edge_pending: assert property (
    @(posedge clk) disable iff (!rst_n)
    stable_edge |=> pend_bit)
    else $error("stable change lost");

  a_irq_enabled: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pend_bit && en_bit && !wr_stat) |=> link_stable_irq)
    else $error("enabled pending event not reported");

  a_alt_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!stable_edge && !pend_bit) |=> !pend_bit)
    else $error("pending set without main edge");

  a_clear_one: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_stat && clr_bit && !stable_edge) |=> !pend_bit)
    else $error("write one did not clear");

  a_keep_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_stat && !clr_bit && pend_bit) |=> pend_bit)
    else $error("write zero cleared a pending bit");

  a_poll_masked: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pend_bit && !en_bit) |=> !link_stable_irq)
    else $error("masked event reported");

  a_poll_shows: assert property (
    @(posedge clk) disable iff (!rst_n)
    (stable_edge && !en_bit) |=> pend_bit)
    else $error("masked event not shown for polling");

  a_reserved_bits_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && sel_ctrl) |=> (reg_rdata[5:3] == 3'b000))
    else $error("reserved bits not zero");

  a_stable_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && sel_ctrl) |=> (reg_rdata[BIT_CLK_STABLE] == $past(clk_stable)))
    else $error("stable bit read not from hardware");

  a_stat_reserved_bits: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && sel_stat) |=> (reg_rdata[7:1] == 7'h00))
    else $error("status reserved bits not zero");

  a_en_reserved_bits: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && sel_en) |=> (reg_rdata[7:2] == 6'h00))
    else $error("enable reserved bits not zero");

  a_unmapped_zero: assert property (
    @(posedge clk) disable iff (!rst_n)
    (reg_rd && !sel_ctrl && !sel_stat && !sel_en) |=> (reg_rdata == 8'h00))
    else $error("unmapped read not zero");
endmodule : tmds_tx_soft_reset_control

/* File: testbench/host_model.sv */
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata
);
  int w = 0;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    {reg_addr, reg_wdata} <= {a, d};
    @(posedge clk);
    reg_wr <= 1'h0;
    reg_wdata <= ~d; // a released bus no longer shows the last byte
    reg_addr <= ~a;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    reg_addr <= ~a;
  endtask : rd
  // page writes land on unmapped locations 0 to 7 of this bus
  task automatic soft_reset(input logic [7:0] keep);
    int n;
    n = 8 - (w % 8);
    repeat (n) begin
      wr(8'(w % 8), 8'h00);
      w++;
    end
    wr(8'h40, keep | 8'h01);
    wr(8'h40, keep);
  endtask : soft_reset
endmodule : host_model

/* File: testbench/tb_tmds_tx_soft_reset_control.sv */
`timescale 1ns/1ps
module tb_tmds_tx_soft_reset_control;
  logic       clk = 0, rst_n = 0, lock = 0, alt = 0, chg = 0, rd_d = 0;
  logic       reg_wr, reg_rd, sec_rst, gcp, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, q[$];
  logic [7:0] adr[4] = '{8'h40, 8'h3e, 8'h3f, 8'h12};
  int         n_fail = 0, checks = 0, cyc = 0;
  always #12.5 clk = ~clk;
  host_model i_host_model (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  tmds_tx_soft_reset_control #(.STABLE_COUNT(20))
    i_tmds_tx_soft_reset_control (.clk(clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pixel_clock_lock(lock), .pixel_clock_alt_lock(alt),
    .pixel_clock_change(chg), .section_reset(sec_rst),
    .gcp_enable(gcp), .link_stable_irq(irq));
  task automatic chk(input string s, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic w(input logic [7:0] a, d);
    i_host_model.wr(a, d);
  endtask : w
  task automatic r(input logic [7:0] a, e);
    q.push_back(e);
    i_host_model.rd(a);
  endtask : r
  // read data is registered, so it is judged one edge after the strobe
  always @(posedge clk) begin
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    if (rd_d && q.size() > 0) chk("reg_rdata", q.pop_front(), reg_rdata);
    if (cyc == 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(3076));
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    for (int i = 0; i < 4; i++) r(adr[i], 8'h00);
    d = 8'($urandom);
    w(8'h40, d);
    r(8'h40, d & 8'h05);
    chk("gcp_enable", {7'h0, d[2] & ~d[0]}, 8'(gcp));
    w(8'h3f, 8'h02);
    w(8'h40, 8'h01);
    repeat (2) @(posedge clk);
    chk("section_reset", 8'h01, 8'(sec_rst));
    r(8'h3f, 8'h02);
    w(8'h40, 8'h00);
    i_host_model.soft_reset(8'h00);
    {lock, alt} <= 2'h3;
    repeat (30) @(posedge clk);
    chk("section_reset", 8'h00, 8'(sec_rst));
    r(8'h40, 8'hc0);
    r(8'h3e, 8'h01);
    chk("irq", 8'h00, 8'(irq));
    w(8'h3f, 8'h01);
    repeat (2) @(posedge clk);
    chk("irq", 8'h01, 8'(irq));
    w(8'h3e, 8'h00);
    r(8'h3e, 8'h01);
    w(8'h3e, 8'h01);
    r(8'h3e, 8'h00);
    chk("irq", 8'h00, 8'(irq));
    w(8'h40, 8'hfe);
    r(8'h40, 8'hc4);
    chk("gcp_enable", 8'h01, 8'(gcp));
    w(8'h40, 8'h00);
    alt <= 1'h0;
    repeat (30) @(posedge clk);
    chk("gcp_enable", 8'h00, 8'(gcp));
    r(8'h40, 8'h40);
    r(8'h3e, 8'h00);
    chg <= 1'h1;
    @(posedge clk);
    chg <= 1'h0;
    repeat (3) @(posedge clk);
    r(8'h40, 8'h00);
    i_host_model.soft_reset(8'h00);
    repeat (30) @(posedge clk);
    r(8'h40, 8'h40);
    r(8'h3e, 8'h01);
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule : tb_tmds_tx_soft_reset_control
